/* rtl/nese_pkg.sv */
`default_nettype none
package nese_pkg;
    // Bus geometry
    localparam int          NESE_AW              = 12;
    localparam int          NESE_DW              = 32;
    localparam int          NESE_NEV             = 16;   // Width of the enable register
    // Register byte addresses
    localparam logic [11:0] NESE_ENABLE_OFF      = 12'h034;
    localparam logic [11:0] NESE_STATUS_OFF      = 12'h030;
    localparam logic [11:0] NESE_IRQ_MASK_OFF    = 12'h040;
    // Field positions of the enable register
    localparam int          NESE_CMD_DONE_BIT    = 0;
    localparam int          NESE_XFER_DONE_BIT   = 1;
    localparam int          NESE_BLOCK_GAP_BIT   = 2;
    localparam int          NESE_DMA_BIT         = 3;
    localparam int          NESE_BUF_WR_BIT      = 4;
    localparam int          NESE_BUF_RD_BIT      = 5;
    localparam int          NESE_INSERT_BIT      = 6;
    localparam int          NESE_REMOVE_BIT      = 7;
    localparam int          NESE_CARD_IRQ_BIT    = 8;
    localparam int          NESE_ERROR_BIT       = 15;
    // Writable bits: 08..00; 15 and 14..09 are held at zero
    localparam logic [15:0] NESE_ENABLE_WMASK    = 16'h01FF;
    localparam logic [15:0] NESE_ENABLE_RESET    = 16'h0000;
    localparam logic [15:0] NESE_STATUS_RESET    = 16'h0000;
    localparam logic [15:0] NESE_MASK_RESET      = 16'h0000;
    localparam logic [31:0] NESE_READ_ZERO       = 32'h0000_0000;
    // Bus slave state
    typedef enum logic [0:0] {NESE_IDLE, NESE_ACCESS} nese_bus_state_t;
endpackage : nese_pkg
`default_nettype wire

/* rtl/nese_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Register write strobes shared between the bus slave and the capture block
interface nese_reg_if;
    logic                       wr_enable;   // Write to enable register
    logic                       wr_status;   // Write-one-to-clear status
    logic                       wr_mask;     // Write to interrupt mask
    logic [15:0]                wdata;       // Write data, low half
    logic [15:0]                enable_q;    // Current enable register
    logic [15:0]                status_q;    // Current status register
    modport slave  (output wr_enable, output wr_status, output wr_mask, output wdata,
                    input enable_q, input status_q);
    modport core   (input wr_enable, input wr_status, input wr_mask, input wdata,
                    output enable_q, output status_q);
endinterface : nese_reg_if
`default_nettype wire

/* rtl/nese_apb_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// APB decode only; the top adds the wait state and registers the answer
module nese_apb_slave
    import nese_pkg::*;
(
    input  wire logic                  pclk,     // Bus clock
    input  wire logic                  presetn,  // Async reset, low
    input  wire logic                  psel,     // Select
    input  wire logic                  penable,  // Access phase
    input  wire logic                  pwrite,   // Direction
    input  wire logic [NESE_AW-1:0]    paddr,    // Byte address
    input  wire logic [NESE_DW-1:0]    pwdata,   // Write data
    input  wire logic [15:0]           mask_q,   // Mask register for readback
    output logic      [NESE_DW-1:0]    prdata,   // Read data
    output logic                       pslverr,  // Error on unmapped address
    nese_reg_if.slave                  regs      // Strobes to the core
);
    logic access;
    logic hit;
    assign access = psel && penable;
    assign hit    = (paddr == NESE_ENABLE_OFF) || (paddr == NESE_STATUS_OFF)
                 || (paddr == NESE_IRQ_MASK_OFF);

    // Write strobes are high in both access cycles; the top commits only when pready is high
    assign regs.wr_enable = access && pwrite && (paddr == NESE_ENABLE_OFF);
    assign regs.wr_status = access && pwrite && (paddr == NESE_STATUS_OFF);
    assign regs.wr_mask   = access && pwrite && (paddr == NESE_IRQ_MASK_OFF);
    assign regs.wdata     = pwdata[15:0];
    assign pslverr        = access && !hit;

    // Read mux; upper half and unmapped addresses read zero
    always_comb begin
        prdata = NESE_READ_ZERO;
        if (access && !pwrite) begin
            case (paddr)
                NESE_ENABLE_OFF:   prdata = {16'h0000, regs.enable_q};
                NESE_STATUS_OFF:   prdata = {16'h0000, regs.status_q};
                NESE_IRQ_MASK_OFF: prdata = {16'h0000, mask_q};
                default:           prdata = NESE_READ_ZERO;
            endcase
        end
    end
endmodule : nese_apb_slave
`default_nettype wire

/* rtl/nese_top.sv */
// Functional notes
// - Events latch only while their enable is set
// - Bit 15 read-only, always zero
// - Card-interrupt enable low drops request immediately
// - Card-interrupt detection paused while enable low
// - Removal bit 7, insertion bit 6 enables
// - Read-ready bit 5, write-ready bit 4
// - DMA interrupt enable at bit 3
// - Block gap 2, transfer 1, command 0
// - Enable low clears held card-interrupt state
`timescale 1ns/1ps
`default_nettype none
module nese_top
    import nese_pkg::*;
(
    input  wire logic                  pclk,          // Controller clock, 40 MHz
    input  wire logic                  presetn,       // Async reset, low
    input  wire logic                  psel,          // APB select
    input  wire logic                  penable,       // APB access phase
    input  wire logic                  pwrite,        // APB direction
    input  wire logic [NESE_AW-1:0]    paddr,         // APB byte address
    input  wire logic [NESE_DW-1:0]    pwdata,        // APB write data
    output logic      [NESE_DW-1:0]    prdata,        // APB read data
    output logic                       pready,        // APB ready
    output logic                       pslverr,       // APB error
    input  wire logic [8:0]            event_pulse,   // Raw normal events, bits 8..0
    output logic                       card_irq_req,  // Card-interrupt request to system
    output logic                       irq            // Combined interrupt, level
);
    import nese_pkg::*;

    nese_reg_if regs ();

    logic [15:0]        enable_reg;
    logic [15:0]        status_reg;
    logic [15:0]        mask_reg;
    logic               card_sample_reg;
    logic               irq_reg;
    logic               card_req_reg;
    logic [NESE_DW-1:0] prdata_comb;
    logic               pslverr_comb;
    logic [15:0]        set_vec;
    logic [15:0]        clr_vec;
    logic [15:0]        status_next;
    logic [15:0]        enable_next;
    nese_bus_state_t    bus_state_reg;
    nese_bus_state_t    bus_state_next;
    logic               commit;
    logic               card_en_now;

    nese_apb_slave u_slave (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .mask_q  (mask_reg),
        .prdata  (prdata_comb),
        .pslverr (pslverr_comb),
        .regs    (regs)
    );

    assign regs.enable_q = enable_reg;
    assign regs.status_q = status_reg;

    // Only bits 8..0 are stored; 15 and 14..9 stay zero
    assign enable_next = regs.wdata & NESE_ENABLE_WMASK;

    // Writes land only at the edge that completes the transfer, never in the wait state
    assign commit      = pready;

    // Card enable as it stands after this edge, so a clearing write acts at once
    assign card_en_now = (regs.wr_enable && commit) ? enable_next[NESE_CARD_IRQ_BIT]
                                                    : enable_reg[NESE_CARD_IRQ_BIT];

    // Enable register, bits 8..0 read-write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= NESE_ENABLE_RESET;
        end else if (regs.wr_enable && commit) begin
            enable_reg <= enable_next;
        end
    end

    // Interrupt mask, same layout as status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= NESE_MASK_RESET;
        end else if (regs.wr_mask && commit) begin
            mask_reg <= regs.wdata & NESE_ENABLE_WMASK;
        end
    end

    // Card-interrupt level is held only while enabled; cleared otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_sample_reg <= 1'b0;
        end else if (!card_en_now) begin
            card_sample_reg <= 1'b0;
        end else begin
            card_sample_reg <= event_pulse[NESE_CARD_IRQ_BIT];
        end
    end

    // Set vector: each event gated by its enable bit
    genvar gi;
    generate
        for (gi = 0; gi < NESE_NEV; gi++) begin : g_set
            if (gi < NESE_CARD_IRQ_BIT) begin : g_evt
                assign set_vec[gi] = event_pulse[gi] & enable_reg[gi];
            end else if (gi == NESE_CARD_IRQ_BIT) begin : g_card
                assign set_vec[gi] = card_sample_reg & enable_reg[gi];
            end else begin : g_none
                assign set_vec[gi] = 1'b0;
            end
        end
    endgenerate

    // Write-one-to-clear; a set in the same cycle wins over the clear
    assign clr_vec     = (regs.wr_status && commit) ? regs.wdata : 16'h0000;
    // Card bit also drops when its enable is cleared, withdrawing the request
    assign status_next = ((status_reg & ~clr_vec) | set_vec)
                       & {7'h00, card_en_now, 8'hFF};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= NESE_STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // Request outputs registered; computed from next status so clearing acts at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg      <= 1'b0;
            card_req_reg <= 1'b0;
        end else begin
            irq_reg      <= |(status_next & mask_reg);
            card_req_reg <= status_next[NESE_CARD_IRQ_BIT] & mask_reg[NESE_CARD_IRQ_BIT];
        end
    end

    // Bus phase: the first access cycle is a wait state while the answer registers
    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            NESE_IDLE: begin
                if (psel && penable) begin
                    bus_state_next = NESE_ACCESS;
                end
            end
            NESE_ACCESS: begin
                bus_state_next = NESE_IDLE;
            end
            default: begin
                bus_state_next = NESE_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state_reg <= NESE_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // Registered bus answer: one wait state, pready high in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= NESE_READ_ZERO;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            prdata  <= prdata_comb;
            pslverr <= pslverr_comb;
            pready  <= (bus_state_next == NESE_ACCESS);
        end
    end

    assign irq          = irq_reg;
    assign card_irq_req = card_req_reg;
endmodule : nese_top
`default_nettype wire

/* test/nese_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks; enable bit 8 is shadowed from completed bus writes
module nese_props
    import nese_pkg::*;
(
    input wire logic               pclk,         // Clock
    input wire logic               presetn,      // Reset, low
    input wire logic               psel,         // Select
    input wire logic               penable,      // Access phase
    input wire logic               pwrite,       // Direction
    input wire logic [NESE_AW-1:0] paddr,        // Address
    input wire logic [NESE_DW-1:0] pwdata,       // Write data
    input wire logic [NESE_DW-1:0] prdata,       // Read data
    input wire logic               pready,       // Ready
    input wire logic               pslverr,      // Error
    input wire logic [8:0]         event_pulse,  // Events
    input wire logic               card_irq_req, // Card request
    input wire logic               irq           // Interrupt
);
    wire logic acc = psel && penable && pready;
    wire logic wen = acc && pwrite && paddr == NESE_ENABLE_OFF;
    logic      en8_reg;
    // Shadow of the card enable, so the checker needs no internal probe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) en8_reg <= 1'b0;
        else if (wen) en8_reg <= pwdata[8];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after wait state");
    a_ready_single: assert property (pready |=> !pready) else $error("pready held too long");
    a_enable_hi_zero: assert property (acc && !pwrite && paddr == NESE_ENABLE_OFF |->
        prdata[31:9] == 23'h0) else $error("enable upper bits set");
    a_card_req_drop: assert property (wen && !pwdata[8] |=> !card_irq_req)
        else $error("card request held");
    a_card_held_low: assert property (!en8_reg && !$past(en8_reg) |-> !card_irq_req)
        else $error("card request while disabled");
    a_card_req_cause: assert property ($rose(card_irq_req) |-> $past(event_pulse[8], 2)
        || $past(event_pulse[8], 3) || $past(acc && pwrite, 1) || $past(acc && pwrite, 2))
        else $error("card request without cause");
    a_irq_rise_cause: assert property ($rose(irq) |-> $past(|event_pulse, 2)
        || $past(|event_pulse, 3) || $past(acc && pwrite, 1) || $past(acc && pwrite, 2))
        else $error("irq without cause");
    a_req_in_irq: assert property (card_irq_req |-> irq) else $error("card request not in irq");
    a_mapped_no_err: assert property (acc && (paddr == NESE_ENABLE_OFF ||
        paddr == NESE_STATUS_OFF || paddr == NESE_IRQ_MASK_OFF) |-> !pslverr) else $error("pslverr");
    c_card_req: cover property (card_irq_req);
    c_card_drop: cover property ($fell(card_irq_req));
    c_unmapped: cover property (acc && pslverr);
endmodule : nese_props
bind nese_top nese_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_pulse(event_pulse),
    .card_irq_req(card_irq_req), .irq(irq));
`default_nettype wire

/* test/nese_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module nese_top_tb;
    import nese_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, card_irq_req, irq;
    logic [8:0] event_pulse = 9'h000, en, v;
    logic [32:0] q[$], exp_v;
    int fails = 0, cmp_count = 0, cyc = 0, seed = 43;
    nese_top u_nese_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_pulse(event_pulse), .card_irq_req(card_irq_req), .irq(irq));
    always #12.5 pclk = ~pclk;
    task automatic results;
        if (q.size() != 0) begin
            fails++;
            $display("unexpected at %0t: %0d reads never answered", $time, q.size());
        end
        $display("fails %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [32:0] a, input logic [32:0] e);
        cmp_count++;
        if (a !== e) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, a, e);
        end
    endtask : chk
    // Reads note {pslverr, prdata} expected; the watcher compares at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        if (!w) q.push_back({(a != NESE_ENABLE_OFF && a != NESE_STATUS_OFF && a != NESE_IRQ_MASK_OFF), d});
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic ev(input logic [8:0] v);
        @(posedge pclk);
        event_pulse <= v;
        @(posedge pclk);
        event_pulse <= 9'h000;
        repeat (3) @(posedge pclk);
        #1;
    endtask : ev
    // Watcher: pairs each completed read with the oldest note
    always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
        exp_v = q.pop_front();
        chk({pslverr, prdata}, exp_v);
    end
    // Hang guard
    always @(posedge pclk) if (++cyc > 5000) begin
        fails++;
        results();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, NESE_ENABLE_OFF, 32'h0); apb(0, NESE_STATUS_OFF, 32'h0);
        apb(0, NESE_IRQ_MASK_OFF, 32'h0); apb(0, 12'hFFC, 32'h0);
        apb(1, NESE_ENABLE_OFF, 32'hFFFF_FFFF); apb(0, NESE_ENABLE_OFF, 32'h1FF);
        // One enable at a time, then random mixes; status must equal enable AND event
        for (int i = 0; i < 16; i++) begin
            en = (i < 9) ? 9'(1 << i) : 9'($random(seed));
            apb(1, NESE_ENABLE_OFF, {23'h0, en});
            v = (i < 9) ? 9'h1FF : 9'($random(seed));
            ev(v);
            apb(0, NESE_STATUS_OFF, {23'h0, en & v});
            apb(1, NESE_STATUS_OFF, 32'h1FF);
        end
        apb(1, NESE_IRQ_MASK_OFF, 32'h1FF); apb(1, NESE_ENABLE_OFF, 32'h1FF);
        ev(9'h100); chk(card_irq_req, 1); chk(irq, 1);
        // Software clears card-interrupt enable bit 8 before servicing it
        apb(1, NESE_ENABLE_OFF, 32'h0FF); @(posedge pclk); #1; chk(card_irq_req, 0);
        apb(0, NESE_STATUS_OFF, 32'h0); ev(9'h100); chk(card_irq_req, 0);
        apb(1, NESE_ENABLE_OFF, 32'h1FF); ev(9'h100); chk(card_irq_req, 1);
        apb(1, NESE_STATUS_OFF, 32'h100); repeat (2) @(posedge pclk); #1; chk(irq, 0);
        apb(1, NESE_IRQ_MASK_OFF, 32'h0); ev(9'h001); chk(irq, 0);
        apb(1, NESE_IRQ_MASK_OFF, 32'h001); repeat (2) @(posedge pclk); #1; chk(irq, 1);
        results();
    end
endmodule : nese_top_tb
`default_nettype wire
